// [verilog/adc_test_and_tuning_regs.sv]
// test pattern, filter cutoff and preamp offset registers of an eight-channel receiver
// assumes the serial control port delivers decoded byte accesses and the channel select mask
// assumes converter data is already in the selected output format
`include "adc_tune_map.svh"

// Function
// - four-bit selector picks output test pattern
// - patterns follow selected offset or twos format
// - filter cutoff code, reset value 0x30
// - filter cutoff write is global, ignores select
// - six-bit preamp offset, 50 grade preset
// - offset preset follows 40 and 25 grades
module adc_test_and_tuning_regs
   import adc_tune_pkg::*;
#(
   parameter int NUM_CH = 8,
   parameter int DATA_W = 12
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // register access from the serial control port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [NUM_CH-1:0] i_chan_sel,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // device strapping and format
   input wire logic [1:0] i_speed_grade,
   input wire logic i_twos_comp,
   input wire logic [DATA_W-1:0] i_user_pattern,
   // converter data
   input wire logic i_sample_valid,
   input wire logic [NUM_CH*DATA_W-1:0] i_adc_data,
   output logic [NUM_CH*DATA_W-1:0] o_chan_data,
   output logic [NUM_CH-1:0] o_chan_valid,
   // analog control
   output logic [NUM_CH-1:0] o_test_active,
   output logic [3:0] o_filter_cutoff,
   output logic [NUM_CH*6-1:0] o_preamp_offset
);

   reg_state_t r_q;
   reg_state_t r_d;

   // offset preset by speed grade; unknown grades fall back to the table reset
   function automatic logic [7:0] grade_preset(input logic [1:0] g);
      case (g)
         `GRADE_50: grade_preset = {2'b00, `OA_PRESET_50};
         `GRADE_40: grade_preset = {2'b00, `OA_PRESET_40};
         `GRADE_25: grade_preset = {2'b00, `OA_PRESET_25};
         default: grade_preset = `OA_RESET;
      endcase
   endfunction : grade_preset

   // lowest selected channel answers reads; channel 0 when none selected
   function automatic logic [2:0] first_chan(input logic [7:0] sel);
      first_chan = 3'h0;
      for (int k = 7; k >= 0; k--)
      begin
         if (sel[k])
            first_chan = k[2:0];
      end
   endfunction : first_chan

   // mode field of one selector byte; zero lets converter data through
   function automatic logic [3:0] mode_of(input logic [7:0] b);
      mode_of = b[`TP_MODE_MSB:`TP_MODE_LSB];
   endfunction : mode_of

   // only six offset bits exist, so the top two always read back as zero
   function automatic logic [7:0] offs_field(input logic [7:0] b);
      offs_field = {2'b00, b[`OA_FIELD_MSB:0]};
   endfunction : offs_field

   // byte write into every selected channel; an empty mask changes nothing
   function automatic logic [7:0][7:0] masked_write(
      input logic [7:0][7:0] cur,
      input logic [7:0] sel,
      input logic [7:0] val
   );
      masked_write = cur;
      for (int c = 0; c < 8; c++)
      begin
         if (sel[c])
            masked_write[c] = val;
      end
   endfunction : masked_write

   // write decode, read mux, test-active flags
   always_comb
   begin
      logic [7:0] sel8;
      logic [2:0] rch;
      sel8 = 8'h00;
      sel8[NUM_CH-1:0] = i_chan_sel;
      rch = first_chan(sel8);
      r_d = r_q;
      r_d.rvalid = i_reg_rd;
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            // local registers land only in the selected channels
            `OFS_TEST_PATTERN: r_d.test = masked_write(r_q.test, sel8, i_reg_wdata);
            // one shared filter, so the select mask is ignored here
            `OFS_FILTER_CUTOFF: r_d.filt = i_reg_wdata;
            `OFS_OFFSET_ADJUST: r_d.offs = masked_write(r_q.offs, sel8, offs_field(i_reg_wdata));
            default: r_d.filt = r_q.filt;
         endcase
      end
      // read from the old state, so a read beside a write returns the old byte
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            `OFS_TEST_PATTERN: r_d.rdata = r_q.test[rch];
            `OFS_FILTER_CUTOFF: r_d.rdata = r_q.filt;
            `OFS_OFFSET_ADJUST: r_d.rdata = r_q.offs[rch];
            default: r_d.rdata = 8'h00;
         endcase
      end
      // flags follow the next state so they change on the same edge as the selector
      for (int c = 0; c < 8; c++)
         r_d.active[c] = (mode_of(r_d.test[c]) != TM_OFF);
   end

   // state register; sync reset loads the grade preset, which is legal for a clocked load
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         r_q <= '0;
         r_q.filt <= `FC_RESET;
         for (int c = 0; c < 8; c++)
         begin
            r_q.test[c] <= `TP_RESET;
            r_q.offs[c] <= grade_preset(i_speed_grade);
         end
      end
      else
         r_q <= r_d;
   end

   // one generator per channel; each owns its output flops
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      test_pattern_gen #(
         .DATA_W(DATA_W)
      ) u_gen (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .i_sample_valid(i_sample_valid),
         .i_adc_data(i_adc_data[g*DATA_W +: DATA_W]),
         .i_mode(mode_of(r_q.test[g])),
         .i_pn_long_rst(r_q.test[g][`TP_PN_LONG_RST_BIT]),
         .i_pn_short_rst(r_q.test[g][`TP_PN_SHORT_RST_BIT]),
         .i_twos_comp(i_twos_comp),
         .i_user_pattern(i_user_pattern),
         .o_data(o_chan_data[g*DATA_W +: DATA_W]),
         .o_valid(o_chan_valid[g])
      );
      assign o_preamp_offset[g*6 +: 6] = r_q.offs[g][`OA_FIELD_MSB:0];
      assign o_test_active[g] = r_q.active[g];
   end

   // register-driven outputs
   assign o_reg_rdata = r_q.rdata;
   assign o_reg_rvalid = r_q.rvalid;
   assign o_filter_cutoff = r_q.filt[`FC_CODE_MSB:`FC_CODE_LSB];

endmodule : adc_test_and_tuning_regs

// [verilog/adc_tune_map.svh]
// offsets, field positions, reset values and presets of the test and tuning registers
// assumes the serial control port decodes frames into byte-wide register accesses
`ifndef ADC_TUNE_MAP_SVH
`define ADC_TUNE_MAP_SVH

// register offsets
`define OFS_TEST_PATTERN 8'h0d
`define OFS_FILTER_CUTOFF 8'h0f
`define OFS_OFFSET_ADJUST 8'h10

// output_test_pattern_control fields
`define TP_MODE_LSB 0
`define TP_MODE_MSB 3
`define TP_PN_SHORT_RST_BIT 4
`define TP_PN_LONG_RST_BIT 5
`define TP_RESET 8'h00

// filter_cutoff_control fields
`define FC_CODE_LSB 4
`define FC_CODE_MSB 7
`define FC_RESET 8'h30

// lna_offset_adjust fields and speed grade presets
`define OA_FIELD_MSB 5
`define OA_RESET 8'h20
`define OA_PRESET_50 6'h19
`define OA_PRESET_40 6'h1a
`define OA_PRESET_25 6'h1f
`define GRADE_50 2'h0
`define GRADE_40 2'h1
`define GRADE_25 2'h2

// pattern words in offset binary
`define PAT_MIDSCALE 12'h800
`define PAT_POS_FS 12'hfff
`define PAT_NEG_FS 12'h000
`define PAT_CHECK_A 12'haaa
`define PAT_CHECK_B 12'h555
`define PAT_SYNC 12'h03f
`define PAT_MIXED 12'ha0f
`define PAT_WALK_SEED 12'h001
`define FMT_FLIP 12'h800
`define PN_LONG_SEED 23'h7fffff
`define PN_SHORT_SEED 9'h1ff

`endif

// [verilog/adc_tune_pkg.sv]
// types shared by the test and tuning register bank and its pattern generators
// assumes adc_tune_map.svh supplies the numeric constants
package adc_tune_pkg;

   // output test selector codes
   typedef enum logic [3:0] {
      TM_OFF = 4'b0000,
      TM_MIDSCALE = 4'b0001,
      TM_POS_FS = 4'b0010,
      TM_NEG_FS = 4'b0011,
      TM_CHECKER = 4'b0100,
      TM_PN_LONG = 4'b0101,
      TM_PN_SHORT = 4'b0110,
      TM_WORD_TOGGLE = 4'b0111,
      TM_USER = 4'b1000,
      TM_BIT_TOGGLE = 4'b1001,
      TM_SYNC = 4'b1010,
      TM_ONE_BIT_HIGH = 4'b1011,
      TM_MIXED = 4'b1100
   } test_mode_t;

   // pattern generator state
   typedef struct packed {
      logic [22:0] pn_long;
      logic [8:0] pn_short;
      logic phase;
      logic [11:0] walk;
      logic [11:0] dout;
      logic dvalid;
   } gen_state_t;

   // register bank state, one byte per channel for the local registers
   typedef struct packed {
      logic [7:0][7:0] test;
      logic [7:0][7:0] offs;
      logic [7:0] filt;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] active;
   } reg_state_t;

endpackage : adc_tune_pkg

// [verilog/test_pattern_gen.sv]
// one channel's test pattern source and output multiplexer
// assumes adc samples arrive with a one-cycle valid strobe at the sample rate
`include "adc_tune_map.svh"

module test_pattern_gen
   import adc_tune_pkg::*;
#(
   parameter int DATA_W = 12
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // converter data in
   input wire logic i_sample_valid,
   input wire logic [DATA_W-1:0] i_adc_data,
   // pattern control
   input wire logic [3:0] i_mode,
   input wire logic i_pn_long_rst,
   input wire logic i_pn_short_rst,
   input wire logic i_twos_comp,
   input wire logic [DATA_W-1:0] i_user_pattern,
   // data out
   output logic [DATA_W-1:0] o_data,
   output logic o_valid
);

   gen_state_t s_q;
   gen_state_t s_d;
   logic [11:0] raw;

   // long sequence, taps 23 and 18
   function automatic logic [22:0] pn_long_step(input logic [22:0] s);
      pn_long_step = {s[21:0], s[22] ^ s[17]};
   endfunction : pn_long_step

   // short sequence, taps 9 and 5
   function automatic logic [8:0] pn_short_step(input logic [8:0] s);
      pn_short_step = {s[7:0], s[8] ^ s[4]};
   endfunction : pn_short_step

   // pattern selection and sequence advance on each sample
   always_comb
   begin
      s_d = s_q;
      raw = `PAT_MIDSCALE;
      case (test_mode_t'(i_mode))
         TM_MIDSCALE: raw = `PAT_MIDSCALE;
         TM_POS_FS: raw = `PAT_POS_FS;
         TM_NEG_FS: raw = `PAT_NEG_FS;
         TM_CHECKER: raw = s_q.phase ? `PAT_CHECK_B : `PAT_CHECK_A;
         TM_PN_LONG: raw = s_q.pn_long[11:0];
         TM_PN_SHORT: raw = {s_q.pn_short, s_q.pn_long[2:0]};
         TM_WORD_TOGGLE: raw = s_q.phase ? `PAT_NEG_FS : `PAT_POS_FS;
         TM_USER: raw = i_user_pattern[11:0];
         TM_BIT_TOGGLE: raw = {11'h000, ~s_q.phase};
         TM_SYNC: raw = `PAT_SYNC;
         TM_ONE_BIT_HIGH: raw = s_q.walk;
         TM_MIXED: raw = `PAT_MIXED;
         default: raw = `PAT_MIDSCALE;
      endcase
      s_d.dvalid = i_sample_valid;
      if (i_sample_valid)
      begin
         s_d.phase = ~s_q.phase;
         s_d.walk = {s_q.walk[10:0], s_q.walk[11]};
         s_d.pn_long = pn_long_step(s_q.pn_long);
         s_d.pn_short = pn_short_step(s_q.pn_short);
         if (i_mode == TM_OFF)
            s_d.dout = i_adc_data;
         else
            s_d.dout = raw ^ (i_twos_comp ? `FMT_FLIP : 12'h000);
      end
      // generators held at seed while their reset bits are set
      if (i_pn_long_rst)
         s_d.pn_long = `PN_LONG_SEED;
      if (i_pn_short_rst)
         s_d.pn_short = `PN_SHORT_SEED;
   end

   // state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.pn_long <= `PN_LONG_SEED;
         s_q.pn_short <= `PN_SHORT_SEED;
         s_q.walk <= `PAT_WALK_SEED;
      end
      else
         s_q <= s_d;
   end

   assign o_data = s_q.dout;
   assign o_valid = s_q.dvalid;

endmodule : test_pattern_gen

// [testbench/adc_tune_chk_assertions.sv]
// protocol and register checks for the test and tuning register bank
// assumes binding to the top module, one clock domain with sync active low reset
module adc_tune_chk #(
   parameter int NUM_CH = 8,
   parameter int DATA_W = 12
)
(
   // clock, reset and register port
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [NUM_CH-1:0] i_chan_sel,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   // data path and analog control
   input wire logic i_sample_valid,
   input wire logic [NUM_CH*DATA_W-1:0] o_chan_data,
   input wire logic [NUM_CH-1:0] o_chan_valid,
   input wire logic [NUM_CH-1:0] o_test_active,
   input wire logic [3:0] o_filter_cutoff,
   input wire logic [NUM_CH*6-1:0] o_preamp_offset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // register port answers
   a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray read valid");
   a_unmapped_read: assert property (i_reg_rd && !(i_reg_addr inside {8'h0d, 8'h0f, 8'h10})
      |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   // second write within a cycle would mask the figure, so it is excluded
   a_filter_follow: assert property (i_reg_wr && i_reg_addr == 8'h0f ##1 !(i_reg_wr && i_reg_addr == 8'h0f)
      |-> ##1 o_filter_cutoff == $past(i_reg_wdata[7:4], 2)) else $error("cutoff not updated");
   a_active_follow: assert property (i_reg_wr && i_reg_addr == 8'h0d && i_chan_sel[0] ##1 !i_reg_wr
      |-> ##1 o_test_active[0] == ($past(i_reg_wdata[3:0], 2) != 4'h0)) else $error("active flag wrong");
   a_valid_pulse: assert property (i_sample_valid |=> o_chan_valid == {NUM_CH{1'b1}}) else $error("no valid");
   a_data_hold: assert property (!i_sample_valid |=> $stable(o_chan_data)) else $error("data moved");
   a_offs_read: assert property (i_reg_rd && i_reg_addr == 8'h10 && i_chan_sel[0] && !i_reg_wr && !$past(i_reg_wr)
      |=> o_reg_rdata[5:0] == o_preamp_offset[5:0]) else $error("offset read mismatch");
   a_offs_high: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h10
      |-> o_reg_rdata[7:6] == 2'b00) else $error("offset upper bits set");

   // main scenarios
   c_test_write: cover property (i_reg_wr && i_reg_addr == 8'h0d && i_chan_sel[0]);
   c_zero_read: cover property (o_reg_rvalid && o_reg_rdata == 8'h00);
   c_test_sample: cover property (i_sample_valid && o_test_active[0]);
endmodule : adc_tune_chk

bind adc_test_and_tuning_regs adc_tune_chk #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) adc_tune_chk_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_chan_sel(i_chan_sel), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_sample_valid(i_sample_valid), .o_chan_data(o_chan_data), .o_chan_valid(o_chan_valid),
   .o_test_active(o_test_active), .o_filter_cutoff(o_filter_cutoff), .o_preamp_offset(o_preamp_offset));

// [testbench/test_adc_test_and_tuning_regs.sv]
// self-checking bench for the test and tuning register bank
// assumes 8 channels of 12 bits, inputs driven 1 ns after each rising edge
module test_adc_test_and_tuning_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_twos_comp, i_sample_valid, o_reg_rvalid;
   logic [7:0] i_reg_addr, i_reg_wdata, i_chan_sel, o_reg_rdata, o_chan_valid, o_test_active;
   logic [1:0] i_speed_grade;
   logic [11:0] i_user_pattern;
   logic [95:0] i_adc_data, o_chan_data;
   logic [47:0] o_preamp_offset;
   logic [3:0] o_filter_cutoff;
   int err_total = 0;
   int n_compared = 0;
   int n_strobe = 0;
   // grade 11 has no preset of its own and falls back to the table reset
   logic [5:0] pre [4] = '{6'h19, 6'h1a, 6'h1f, 6'h20};
   // selectors whose word depends on the strobe count
   logic [3:0] pmodes [4] = '{4'h4, 4'h7, 4'h9, 4'hb};
   // selector bytes and their offset binary words; 0x25 holds the long generator at seed, 0x36 holds both generators at seed
   logic [7:0] codes [9] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h0a, 8'h0c, 8'h0d, 8'h25, 8'h36};
   logic [11:0] pats [9] = '{12'h800, 12'hfff, 12'h000, 12'h3c5, 12'h03f, 12'ha0f, 12'h800, 12'hfff, 12'hfff};

   adc_test_and_tuning_regs adc_test_and_tuning_regs_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_chan_sel(i_chan_sel), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_speed_grade(i_speed_grade), .i_twos_comp(i_twos_comp), .i_user_pattern(i_user_pattern),
      .i_sample_valid(i_sample_valid), .i_adc_data(i_adc_data), .o_chan_data(o_chan_data),
      .o_chan_valid(o_chan_valid), .o_test_active(o_test_active), .o_filter_cutoff(o_filter_cutoff),
      .o_preamp_offset(o_preamp_offset));

   task automatic cmp(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   task automatic tick;
      @(posedge i_clk);
      #1;
   endtask : tick

   // each access ends with an idle cycle so strobes never toggle twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] s);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      i_chan_sel = s;
      tick;
      i_reg_wr = 1'b0;
      tick;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] s, input logic [7:0] exp);
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      i_chan_sel = s;
      tick;
      i_reg_rd = 1'b0;
      cmp("rvalid", 48'h1, o_reg_rvalid);
      cmp("rdata", exp, o_reg_rdata);
      tick;
      cmp("rvalid end", 48'h0, o_reg_rvalid);
   endtask : rd

   // channel 1 is never put in test mode, so it must pass converter data
   task automatic samp(input logic [11:0] e0);
      i_sample_valid = 1'b1;
      tick;
      n_strobe++;
      i_sample_valid = 1'b0;
      cmp("chan valid", 48'hff, o_chan_valid);
      cmp("chan0", e0, o_chan_data[11:0]);
      cmp("chan1", 48'h5a3, o_chan_data[23:12]);
      tick;
   endtask : samp

   // expected word of a phase-driven pattern after n strobes since reset
   function automatic logic [11:0] phase_pat(input logic [3:0] m, input int n);
      case (m)
         4'h4: phase_pat = n[0] ? 12'h555 : 12'haaa;
         4'h7: phase_pat = n[0] ? 12'h000 : 12'hfff;
         4'h9: phase_pat = {11'h000, ~n[0]};
         default: phase_pat = 12'h001 << (n % 12);
      endcase
   endfunction : phase_pat

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   // clock
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // watchdog cuts a hang short
   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      summarize;
   end

   // main sequence
   initial
   begin
      {i_reg_wr, i_reg_rd, i_twos_comp, i_sample_valid} = 4'h0;
      {i_reg_addr, i_reg_wdata, i_chan_sel} = 24'h000000;
      i_user_pattern = 12'h3c5;
      i_adc_data = {8{12'h5a3}};
      for (int g = 3; g >= 0; g--)
      begin
         i_rst_n = 1'b0;
         i_speed_grade = g[1:0];
         repeat (12) tick;
         i_rst_n = 1'b1;
         cmp("offsets", {8{pre[g]}}, o_preamp_offset);
         rd(8'h10, 8'h01, {2'b00, pre[g]});
      end
      cmp("cutoff", 48'h3, o_filter_cutoff);
      rd(8'h0f, 8'h00, 8'h30);
      rd(8'h0d, 8'h01, 8'h00);
      wr(8'h0f, 8'h60, 8'h00);
      cmp("cutoff", 48'h6, o_filter_cutoff);
      rd(8'h0f, 8'h00, 8'h60);
      wr(8'h10, 8'hff, 8'h04);
      rd(8'h10, 8'h04, 8'h3f);
      cmp("offset ch0", 48'h19, o_preamp_offset[5:0]);
      wr(8'h11, 8'h55, 8'hff);
      rd(8'h11, 8'hff, 8'h00);
      for (int t = 0; t < 2; t++)
      begin
         i_twos_comp = t[0];
         wr(8'h0d, 8'h00, 8'h01);
         cmp("active", 48'h0, o_test_active);
         samp(12'h5a3);
         for (int k = 0; k < 9; k++)
         begin
            wr(8'h0d, codes[k], 8'h01);
            cmp("active", 48'h1, o_test_active);
            samp(pats[k] ^ {t[0], 11'h000});
         end
      end
      rd(8'h0d, 8'h01, 8'h36);
      // long sequence released from seed, then the strobe-count patterns
      i_twos_comp = 1'b0;
      wr(8'h0d, 8'h05, 8'h01);
      samp(12'hfff);
      samp(12'hffe);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h0d, {4'h0, pmodes[k]}, 8'h01);
         samp(phase_pat(pmodes[k], n_strobe));
         samp(phase_pat(pmodes[k], n_strobe));
      end
      summarize;
   end
endmodule : test_adc_test_and_tuning_regs
